// File: design/oled_cmd_pkg.sv
// Package of opcodes, reset values, field positions and shared types of the command engine
package oled_cmd_pkg;

  // ==========================================================================
  // Command opcodes
  localparam logic [7:0] OP_CONTRAST    = 8'h81;
  localparam logic [7:0] OP_FOLLOW_RAM  = 8'ha4;
  localparam logic [7:0] OP_ALL_ON      = 8'ha5;
  localparam logic [7:0] OP_NORMAL      = 8'ha6;
  localparam logic [7:0] OP_INVERSE     = 8'ha7;
  localparam logic [7:0] OP_PANEL_OFF   = 8'hae;
  localparam logic [7:0] OP_PANEL_ON    = 8'haf;
  localparam logic [7:0] OP_HSCROLL_R   = 8'h26;
  localparam logic [7:0] OP_HSCROLL_L   = 8'h27;
  localparam logic [7:0] OP_VHSCROLL_R  = 8'h29;
  localparam logic [7:0] OP_VHSCROLL_L  = 8'h2a;
  localparam logic [7:0] OP_SCROLL_STOP = 8'h2e;
  localparam logic [7:0] OP_SCROLL_GO   = 8'h2f;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_CONTRAST   = 8'h7f;
  localparam logic [5:0] RST_START_LINE = 6'h00;
  localparam logic [6:0] RST_COLUMN     = 7'h00;
  localparam logic [5:0] MUX_64_ROWS    = 6'h3f;  // N+1 = 64 rows

  // ==========================================================================
  // Serial byte framing and scroll parameter positions
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [2:0] ARG_START      = 3'h1;
  localparam logic [2:0] ARG_INTERVAL   = 3'h2;
  localparam logic [2:0] ARG_END        = 3'h3;
  localparam logic [2:0] ARG_VOFFSET    = 3'h4;
  localparam logic [2:0] HARGS_LAST     = 3'h5;  // six bytes after 26h/27h
  localparam logic [2:0] VHARGS_LAST    = 3'h4;  // five bytes after 29h/2Ah

  // Frame period in clock cycles; arbitrary default, no figure is given
  localparam int FRAME_CYCLES_DEFAULT = 2500000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DEC_IDLE     = 2'b00,
    DEC_CONTRAST = 2'b01,
    DEC_SCROLL   = 2'b10
  } dec_state_t;

  typedef struct packed {
    logic       left;
    logic       vertical;
    logic [2:0] start_page;
    logic [2:0] interval;
    logic [2:0] end_page;
    logic [5:0] voffset;
  } scroll_setup_t;

  // Frames between scroll steps for each interval code
  function automatic logic [8:0] frames_for(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h005;
    case (code)
      3'b000: n = 9'h005;
      3'b001: n = 9'h040;
      3'b010: n = 9'h080;
      3'b011: n = 9'h100;
      3'b100: n = 9'h003;
      3'b101: n = 9'h004;
      3'b110: n = 9'h019;
      3'b111: n = 9'h002;
      default: n = 9'h005;
    endcase
    return n;
  endfunction

endpackage

// File: design/oled_command_scroll_engine.sv
// Command interpreter and scroll engine of a 128x64 monochrome panel controller
`timescale 1ns/100ps
`default_nettype none
module oled_command_scroll_engine #(
  parameter int FRAME_CYCLES = oled_cmd_pkg::FRAME_CYCLES_DEFAULT
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       INIT_IN_N,
  input  wire logic       SERIAL_CLK,
  input  wire logic       SERIAL_DATA_IN,
  input  wire logic       CHIP_SELECT_N,
  input  wire logic       DATA_SELECT,
  output logic            PANEL_ON,
  output logic            ENTIRE_ON,
  output logic            INVERSE,
  output logic [7:0]      CONTRAST,
  output logic [5:0]      MUX_RATIO,
  output logic            SEG_REMAP,
  output logic            COM_REMAP,
  output logic [5:0]      START_LINE,
  output logic [6:0]      COLUMN_ADDR,
  output logic            RAM_WR_STB,
  output logic [7:0]      RAM_WR_DATA,
  output logic            SCROLL_ACTIVE,
  output logic            SCROLL_LEFT,
  output logic            SCROLL_VERTICAL,
  output logic [2:0]      SCROLL_START_PAGE,
  output logic [2:0]      SCROLL_END_PAGE,
  output logic [8:0]      SCROLL_FRAMES,
  output logic [5:0]      SCROLL_VOFFSET,
  output logic            SCROLL_STEP,
  output logic [6:0]      SCROLL_COL_SHIFT,
  output logic [5:0]      SCROLL_ROW_SHIFT
);

  // ==========================================================================
  // Elaboration check
  if (FRAME_CYCLES < 2) begin : g_frame_check
    $error("FRAME_CYCLES must be at least 2");
  end

  localparam int FW = $clog2(FRAME_CYCLES);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);

  // ==========================================================================
  // Declarations
  rx_byte_if rxb ();

  logic [1:0]                  init_s;
  logic                        init;
  oled_cmd_pkg::dec_state_t    state;
  logic [2:0]                  arg_idx;
  logic [2:0]                  arg_last;
  oled_cmd_pkg::scroll_setup_t setup;
  logic                        setup_ready;
  logic                        cmd_byte;
  logic                        op_byte;
  logic                        arg_byte;
  logic                        go;
  logic                        stop;
  logic [FW-1:0]               frame_cnt;
  logic                        frame_tick;
  logic [8:0]                  step_cnt;

  // ==========================================================================
  // Init pin synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      init_s <= 2'h0;
    end else begin
      init_s <= {init_s[0], INIT_IN_N};
    end
  end

  assign init = ~init_s[1];

  // ==========================================================================
  // Serial receiver
  serial_byte_rx u_rx (
    .clk      (CLK),
    .rst      (RST),
    .init     (init),
    .sclk_pin (SERIAL_CLK),
    .serial_data_in_pin (SERIAL_DATA_IN),
    .cs_n_pin (CHIP_SELECT_N),
    .dc_pin   (DATA_SELECT),
    .rxo      (rxb.rx)
  );

  // ==========================================================================
  // Byte routing
  // select low goes to decoder
  assign cmd_byte = rxb.valid & ~rxb.is_data & ~init;
  assign op_byte  = cmd_byte & (state == oled_cmd_pkg::DEC_IDLE);
  assign arg_byte = cmd_byte & (state != oled_cmd_pkg::DEC_IDLE);
  assign arg_last = setup.vertical ? oled_cmd_pkg::VHARGS_LAST : oled_cmd_pkg::HARGS_LAST;
  assign go       = op_byte & (rxb.data == oled_cmd_pkg::OP_SCROLL_GO) & setup_ready;
  assign stop     = op_byte & (rxb.data == oled_cmd_pkg::OP_SCROLL_STOP);

  // ==========================================================================
  // Decoder state and parameter counter
  // track pending parameters
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state   <= oled_cmd_pkg::DEC_IDLE;
      arg_idx <= 3'h0;
    end else if (init) begin
      state   <= oled_cmd_pkg::DEC_IDLE;
      arg_idx <= 3'h0;
    end else if (cmd_byte) begin
      unique case (state)
        oled_cmd_pkg::DEC_IDLE: begin
          arg_idx <= 3'h0;
          if (rxb.data == oled_cmd_pkg::OP_CONTRAST) begin
            state <= oled_cmd_pkg::DEC_CONTRAST;
          end else if (rxb.data == oled_cmd_pkg::OP_HSCROLL_R || rxb.data == oled_cmd_pkg::OP_HSCROLL_L ||
                       rxb.data == oled_cmd_pkg::OP_VHSCROLL_R || rxb.data == oled_cmd_pkg::OP_VHSCROLL_L) begin
            state <= oled_cmd_pkg::DEC_SCROLL;
          end
        end
        oled_cmd_pkg::DEC_CONTRAST: begin
          state <= oled_cmd_pkg::DEC_IDLE;
        end
        oled_cmd_pkg::DEC_SCROLL: begin
          if (arg_idx == arg_last) begin
            state <= oled_cmd_pkg::DEC_IDLE;
          end
          arg_idx <= arg_idx + 3'h1;
        end
        default: begin
          state <= oled_cmd_pkg::DEC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Scroll setup capture
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      setup <= '0;
    end else if (init) begin
      setup <= '0;
    end else if (op_byte) begin
      if (rxb.data == oled_cmd_pkg::OP_HSCROLL_R || rxb.data == oled_cmd_pkg::OP_HSCROLL_L) begin
        setup.left     <= rxb.data[0];
        setup.vertical <= 1'b0;
        setup.voffset  <= 6'h00;
      end
      if (rxb.data == oled_cmd_pkg::OP_VHSCROLL_R || rxb.data == oled_cmd_pkg::OP_VHSCROLL_L) begin
        setup.left     <= rxb.data[1];
        setup.vertical <= 1'b1;
      end
    end else if (arg_byte && state == oled_cmd_pkg::DEC_SCROLL) begin
      if (arg_idx == oled_cmd_pkg::ARG_START) begin
        setup.start_page <= rxb.data[2:0];
      end
      if (arg_idx == oled_cmd_pkg::ARG_INTERVAL) begin
        setup.interval <= rxb.data[2:0];
      end
      if (arg_idx == oled_cmd_pkg::ARG_END) begin
        setup.end_page <= rxb.data[2:0];
      end
      if (arg_idx == oled_cmd_pkg::ARG_VOFFSET && setup.vertical) begin
        setup.voffset <= rxb.data[5:0];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      setup_ready <= 1'b0;
    end else if (init) begin
      setup_ready <= 1'b0;
    end else if (op_byte && (rxb.data == oled_cmd_pkg::OP_HSCROLL_R || rxb.data == oled_cmd_pkg::OP_HSCROLL_L ||
                             rxb.data == oled_cmd_pkg::OP_VHSCROLL_R || rxb.data == oled_cmd_pkg::OP_VHSCROLL_L)) begin
      setup_ready <= 1'b0;
    end else if (arg_byte && state == oled_cmd_pkg::DEC_SCROLL && arg_idx == arg_last) begin
      setup_ready <= 1'b1;
    end
  end

  // ==========================================================================
  // Contrast register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CONTRAST <= oled_cmd_pkg::RST_CONTRAST;
    end else if (init) begin
      CONTRAST <= oled_cmd_pkg::RST_CONTRAST;
    end else if (arg_byte && state == oled_cmd_pkg::DEC_CONTRAST) begin
      CONTRAST <= rxb.data;
    end
  end

  // ==========================================================================
  // Display flags
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PANEL_ON  <= 1'b0;
      ENTIRE_ON <= 1'b0;
      INVERSE   <= 1'b0;
    end else if (init) begin
      PANEL_ON  <= 1'b0;
      ENTIRE_ON <= 1'b0;
      INVERSE   <= 1'b0;
    end else if (op_byte) begin
      if (rxb.data == oled_cmd_pkg::OP_ALL_ON || rxb.data == oled_cmd_pkg::OP_FOLLOW_RAM) begin
        ENTIRE_ON <= rxb.data[0];
      end
      if (rxb.data == oled_cmd_pkg::OP_INVERSE || rxb.data == oled_cmd_pkg::OP_NORMAL) begin
        INVERSE <= rxb.data[0];
      end
      if (rxb.data == oled_cmd_pkg::OP_PANEL_ON || rxb.data == oled_cmd_pkg::OP_PANEL_OFF) begin
        PANEL_ON <= rxb.data[0];
      end
    end
  end

  // ==========================================================================
  // Format and mapping state; no command here changes it
  // normal mapping held
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MUX_RATIO  <= oled_cmd_pkg::MUX_64_ROWS;
      SEG_REMAP  <= 1'b0;
      COM_REMAP  <= 1'b0;
      START_LINE <= oled_cmd_pkg::RST_START_LINE;
    end else if (init) begin
      MUX_RATIO  <= oled_cmd_pkg::MUX_64_ROWS;
      SEG_REMAP  <= 1'b0;
      COM_REMAP  <= 1'b0;
      START_LINE <= oled_cmd_pkg::RST_START_LINE;
    end
  end

  // ==========================================================================
  // Display RAM write path
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAM_WR_STB  <= 1'b0;
      RAM_WR_DATA <= 8'h00;
      COLUMN_ADDR <= oled_cmd_pkg::RST_COLUMN;
    end else if (init) begin
      RAM_WR_STB  <= 1'b0;
      COLUMN_ADDR <= oled_cmd_pkg::RST_COLUMN;
    end else begin
      RAM_WR_STB <= rxb.valid & rxb.is_data;
      if (rxb.valid && rxb.is_data) begin
        RAM_WR_DATA <= rxb.data;
        COLUMN_ADDR <= COLUMN_ADDR + 7'h01;
      end
    end
  end

  // ==========================================================================
  // Active scroll settings, loaded at start
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SCROLL_ACTIVE     <= 1'b0;
      SCROLL_LEFT       <= 1'b0;
      SCROLL_VERTICAL   <= 1'b0;
      SCROLL_START_PAGE <= 3'h0;
      SCROLL_END_PAGE   <= 3'h0;
      SCROLL_FRAMES     <= 9'h005;
      SCROLL_VOFFSET    <= 6'h00;
    end else if (init || stop) begin
      SCROLL_ACTIVE <= 1'b0;
    end else if (go) begin
      SCROLL_ACTIVE     <= 1'b1;
      SCROLL_LEFT       <= setup.left;
      SCROLL_VERTICAL   <= setup.vertical;
      SCROLL_START_PAGE <= setup.start_page;
      SCROLL_END_PAGE   <= setup.end_page;
      SCROLL_FRAMES     <= oled_cmd_pkg::frames_for(setup.interval);
      SCROLL_VOFFSET    <= setup.voffset;
    end
  end

  // ==========================================================================
  // Frame rate enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      frame_cnt  <= '0;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= (frame_cnt == FRAME_LAST);
      if (frame_cnt == FRAME_LAST) begin
        frame_cnt <= '0;
      end else begin
        frame_cnt <= frame_cnt + FW'(1);
      end
    end
  end

  // ==========================================================================
  // Step timer counts frames between steps
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      step_cnt    <= 9'h000;
      SCROLL_STEP <= 1'b0;
    end else if (init || stop || !SCROLL_ACTIVE || go) begin
      step_cnt    <= 9'h000;
      SCROLL_STEP <= 1'b0;
    end else begin
      SCROLL_STEP <= 1'b0;
      if (frame_tick) begin
        // step after the set frame count
        if (step_cnt + 9'h001 >= SCROLL_FRAMES) begin
          step_cnt    <= 9'h000;
          SCROLL_STEP <= 1'b1;
        end else begin
          step_cnt <= step_cnt + 9'h001;
        end
      end
    end
  end

  // ==========================================================================
  // Accumulated column and row shifts
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SCROLL_COL_SHIFT <= 7'h00;
      SCROLL_ROW_SHIFT <= 6'h00;
    end else if (init || go) begin
      SCROLL_COL_SHIFT <= 7'h00;
      SCROLL_ROW_SHIFT <= 6'h00;
    end else if (SCROLL_STEP && SCROLL_ACTIVE) begin
      SCROLL_COL_SHIFT <= SCROLL_LEFT ? SCROLL_COL_SHIFT - 7'h01 : SCROLL_COL_SHIFT + 7'h01;
      if (SCROLL_VERTICAL) begin
        SCROLL_ROW_SHIFT <= SCROLL_ROW_SHIFT + SCROLL_VOFFSET;
      end
    end
  end

endmodule
`default_nettype wire

// File: design/rx_byte_if.sv
// Interface carrying received bytes from the serial receiver to the decoder
`timescale 1ns/100ps
`default_nettype none
interface rx_byte_if;
  logic       valid;    // One-cycle pulse per complete byte
  logic [7:0] data;     // Received byte, MSB first on the wire
  logic       is_data;  // Data/command select level at the byte's last bit

  modport rx  (output valid, output data, output is_data);
  modport dec (input valid, input data, input is_data);
endinterface
`default_nettype wire

// File: design/serial_byte_rx.sv
// Serial receiver: samples link pins with the core clock and assembles bytes
`timescale 1ns/100ps
`default_nettype none
module serial_byte_rx (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic init,
  input  wire logic sclk_pin,
  input  wire logic serial_data_in_pin,
  input  wire logic cs_n_pin,
  input  wire logic dc_pin,
  rx_byte_if.rx     rxo
);

  // ==========================================================================
  // Pin synchronisers, stage 0 feeds only stage 1
  logic [1:0] sclk_s;
  logic [1:0] serial_data_in_s;
  logic [1:0] csn_s;
  logic [1:0] dc_s;
  logic       sclk_prev;
  logic [7:0] shift;
  logic [2:0] count;
  logic       rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s <= 2'h0;
      serial_data_in_s <= 2'h0;
      csn_s  <= 2'h3;
      dc_s   <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[0], sclk_pin};
      serial_data_in_s <= {serial_data_in_s[0], serial_data_in_pin};
      csn_s  <= {csn_s[0], cs_n_pin};
      dc_s   <= {dc_s[0], dc_pin};
    end
  end

  // Edge finder on the settled link clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s[1];
    end
  end

  assign rise = sclk_s[1] & ~sclk_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift <= 8'h00;
      count <= 3'h0;
    end else if (init || csn_s[1]) begin
      shift <= 8'h00;
      count <= 3'h0;
    end else if (rise) begin
      shift <= {shift[6:0], serial_data_in_s[1]};
      count <= count + 3'h1;
    end
  end

  // Byte hand-off on the eighth rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxo.valid   <= 1'b0;
      rxo.data    <= 8'h00;
      rxo.is_data <= 1'b0;
    end else begin
      rxo.valid <= rise & ~csn_s[1] & ~init & (count == oled_cmd_pkg::LAST_BIT);
      if (rise && count == oled_cmd_pkg::LAST_BIT) begin
        rxo.data    <= {shift[6:0], serial_data_in_s[1]};
        rxo.is_data <= dc_s[1];
      end
    end
  end

endmodule
`default_nettype wire

// File: sim/host_link_model.sv
// Host model that shifts bytes into the serial link
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  output var logic sclk,
  output var logic serial_data_in,
  output var logic cs_n,
  output var logic dc
);
  // ==========================================================================
  // Idle levels
  initial begin
    sclk = 1'b0;
    serial_data_in = 1'b0;
    cs_n = 1'b1;
    dc   = 1'b0;
  end
  // select level held over the whole byte
  task automatic send(input logic [7:0] b, input logic d, input int n);
    int i;
    dc = d;
    cs_n = 1'b0;
    #16;
    for (i = 7; i > 7 - n; i--) begin
      serial_data_in = b[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    // A short byte keeps the link selected
    if (n == 8) begin
      #16;
      cs_n = 1'b1;
      serial_data_in = ~serial_data_in;  // Released line shows no stale bit
    end
  endtask
endmodule
`default_nettype wire

// File: sim/oled_engine_properties.sv
// Concurrent checks on the command engine ports
`timescale 1ns/100ps
`default_nettype none
module oled_engine_properties (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       INIT_IN_N,
  input wire logic       PANEL_ON,
  input wire logic [7:0] CONTRAST,
  input wire logic [5:0] MUX_RATIO,
  input wire logic       SEG_REMAP,
  input wire logic       COM_REMAP,
  input wire logic [5:0] START_LINE,
  input wire logic [6:0] COLUMN_ADDR,
  input wire logic       RAM_WR_STB,
  input wire logic       SCROLL_ACTIVE,
  input wire logic       SCROLL_LEFT,
  input wire logic       SCROLL_VERTICAL,
  input wire logic [8:0] SCROLL_FRAMES,
  input wire logic [5:0] SCROLL_VOFFSET,
  input wire logic       SCROLL_STEP,
  input wire logic [6:0] SCROLL_COL_SHIFT,
  input wire logic [5:0] SCROLL_ROW_SHIFT
);
  // ==========================================================================
  // Port relations
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_MUX: assert property (MUX_RATIO == 6'h3f)
    else $error("row format not 64");
  AST_MAP: assert property (!SEG_REMAP && !COM_REMAP)
    else $error("mapping not normal");
  AST_ORIGIN: assert property (START_LINE == 6'h00)
    else $error("start line not zero");
  AST_INIT: assert property ((!INIT_IN_N) [*5] |-> !PANEL_ON && CONTRAST == 8'h7f && COLUMN_ADDR == 7'h00 && !SCROLL_ACTIVE)
    else $error("init did not force defaults");
  AST_COL: assert property (SCROLL_STEP ##1 SCROLL_ACTIVE |->
    SCROLL_COL_SHIFT == $past(SCROLL_COL_SHIFT) + (SCROLL_LEFT ? 7'h7f : 7'h01))
    else $error("column shift wrong");
  // rows move only with vertical setup
  AST_ROW: assert property (SCROLL_STEP ##1 SCROLL_ACTIVE |->
    SCROLL_ROW_SHIFT == $past(SCROLL_ROW_SHIFT) + (SCROLL_VERTICAL ? SCROLL_VOFFSET : 6'h00))
    else $error("row shift wrong");
  AST_IDLE: assert property (!SCROLL_ACTIVE |-> !SCROLL_STEP)
    else $error("step while stopped");
  AST_WR: assert property (RAM_WR_STB |-> COLUMN_ADDR == $past(COLUMN_ADDR) + 7'h01)
    else $error("column not advanced");
  AST_FRM: assert property (SCROLL_FRAMES inside {9'h005, 9'h040, 9'h080, 9'h100, 9'h003, 9'h004, 9'h019, 9'h002})
    else $error("frame count illegal");
endmodule
bind oled_command_scroll_engine oled_engine_properties u_oled_engine_properties (.*);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the command engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int FC = 8;
  localparam logic [7:0] OPS [7] = '{8'hae, 8'haf, 8'ha5, 8'ha7, 8'ha4, 8'ha6, 8'hae};
  localparam logic [2:0] FLG [7] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h5, 3'h4, 3'h0};
  localparam logic [7:0] SET [4] = '{8'h26, 8'h27, 8'h29, 8'h2a};
  localparam logic [8:0] FR [8] = '{9'h005, 9'h040, 9'h080, 9'h100, 9'h003, 9'h004, 9'h019, 9'h002};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       init_n = 1'b1;
  logic       sclk, serial_data_in, cs_n, dc;
  logic       pon, ent, inv, wstb, act, left, vert, step;
  logic [7:0] con, wdat;
  logic [6:0] col;
  logic [2:0] spg, epg;
  logic [8:0] frm;
  logic [5:0] voff;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         k;
  int         n;

  always #2 clk = ~clk;

  host_link_model u_host_link_model (.sclk(sclk), .serial_data_in(serial_data_in), .cs_n(cs_n), .dc(dc));
  oled_command_scroll_engine #(.FRAME_CYCLES(FC)) u_oled_command_scroll_engine (
    .CLK(clk), .RST(rst), .INIT_IN_N(init_n), .SERIAL_CLK(sclk), .SERIAL_DATA_IN(serial_data_in),
    .CHIP_SELECT_N(cs_n), .DATA_SELECT(dc), .PANEL_ON(pon), .ENTIRE_ON(ent), .INVERSE(inv),
    .CONTRAST(con), .MUX_RATIO(), .SEG_REMAP(), .COM_REMAP(), .START_LINE(), .COLUMN_ADDR(col),
    .RAM_WR_STB(wstb), .RAM_WR_DATA(wdat), .SCROLL_ACTIVE(act), .SCROLL_LEFT(left),
    .SCROLL_VERTICAL(vert), .SCROLL_START_PAGE(spg), .SCROLL_END_PAGE(epg), .SCROLL_FRAMES(frm),
    .SCROLL_VOFFSET(voff), .SCROLL_STEP(step), .SCROLL_COL_SHIFT(), .SCROLL_ROW_SHIFT());

  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host_link_model.send(b, 1'b0, 8);
    repeat (10) @(negedge clk);
  endtask
  task automatic setup(input logic [7:0] op, input logic [2:0] s, iv, e, input logic [5:0] v);
    logic [7:0] p [7];
    int         i;
    p = '{op, 8'h00, {5'h00, s}, {5'h00, iv}, {5'h00, e}, op[3] ? {2'h0, v} : 8'h00, 8'hff};
    cmd(8'h2e);
    for (i = 0; i < (op[3] ? 6 : 7); i++) begin
      cmd(p[i]);
    end
  endtask
  task automatic wait_step();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (step !== 1'b1 && n < 5000);
    if (step !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: no scroll step", $time);
      results();
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk({pon, ent, inv}, 3'h0, "reset flags");
    chk(con, 8'h7f, "reset contrast");
    chk(col, 7'h00, "reset column");
    chk(frm, 9'h005, "reset frames");
    $display("Reset test done");
    for (k = 0; k < 7; k++) begin
      cmd(OPS[k]);
      chk({pon, ent, inv}, FLG[k], "display flags");
    end
    $display("Display mode test done");
    cmd(8'h81);
    u_host_link_model.send(8'h5a, 1'b1, 8);
    repeat (10) @(negedge clk);
    chk(wdat, 8'h5a, "ram data");
    chk(col, 7'h01, "column");
    cmd(8'haf);
    chk({pon, con}, 9'h0af, "contrast");
    cmd(8'he3);
    chk({pon, con}, 9'h0af, "unknown opcode");
    $display("Contrast test done");
    for (k = 0; k < 8; k++) begin
      setup(SET[k % 4], 3'h1, k[2:0], 3'h6, 6'h01);
      cmd(8'h2f);
      chk(frm, FR[k], "frames");
      chk({act, left, vert, spg, epg}, {1'b1, k[0], k[1], 3'h1, 3'h6}, "setup fields");
    end
    wait_step();
    wait_step();
    chk(9'(n), 9'(2 * FC), "step spacing");
    $display("Scroll setup test done");
    setup(8'h26, 3'h1, 3'h7, 3'h3, 6'h00);
    setup(8'h2a, 3'h4, 3'h7, 3'h6, 6'h3f);
    cmd(8'h2f);
    chk({act, left, vert, spg, epg}, 9'h1e6, "latest setup");
    chk(voff, 6'h3f, "row offset");
    wait_step();
    cmd(8'h2e);
    chk(act, 1'b0, "scroll stop");
    u_host_link_model.send(8'h00, 1'b1, 8);
    repeat (40) @(negedge clk);
    $display("Scroll order test done");
    // init held over a partial byte
    cmd(8'haf);
    u_host_link_model.send(8'hf0, 1'b0, 4);
    init_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({pon, con}, 9'h07f, "init values");
    chk(col, 7'h00, "init column");
    init_n = 1'b1;
    repeat (4) @(negedge clk);
    // first byte after init must be aligned
    cmd(8'h81);
    cmd(8'h3c);
    chk(con, 8'h3c, "contrast after init");
    cmd(8'h2f);
    chk(act, 1'b0, "start without setup");
    $display("Init test done");
    results();
  end
endmodule
`default_nettype wire
